// File: src/srcs_rx_ctrl.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - continuous receive enable turns receiver on/off
// - address detect loads only ninth-bit-set frames
// - address detect off accepts every byte
// - eight-bit mode ignores address detect
module srcs_rx_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    output logic irq
);
    typedef struct packed {
        srcs_pkg::srcs_ctrl_t ctrl;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic received_ninth_bit;
        logic [7:0] receive_data_buffer;
        logic buf_full;
        logic [7:0] baud_div;
        logic [7:0] div_cnt;
        logic tick;
        logic [srcs_pkg::IRQ_W-1:0] irq_stat;
        logic [srcs_pkg::IRQ_W-1:0] irq_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } srcs_top_state_t;

    srcs_top_state_t s_reg;
    srcs_top_state_t s_next;
    srcs_pkg::srcs_frame_t frame;
    logic rx_on;
    logic accept;
    logic wr_go;
    logic rd_go;
    logic mapped;
    logic [7:0] csr_view;
    logic [srcs_pkg::IRQ_W-1:0] ev;

    // receiver runs while enabled and no overrun is pending
    assign rx_on = s_reg.ctrl.serial_port_enable
                 & s_reg.ctrl.continuous_receive_enable
                 & ~s_reg.overrun_error_flag;

    srcs_rx_shift #(.OVS(srcs_pkg::OVERSAMPLE)) u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_on),
        .sample_tick(s_reg.tick),
        .nine_bits(s_reg.ctrl.nine_bit_receive_select),
        .rx_pin(rx_pin),
        .frame(frame)
    );

    // address filter only in nine-bit mode with detection on
    assign accept = frame.valid
        & (~s_reg.ctrl.nine_bit_receive_select
           | ~s_reg.ctrl.address_detect_enable
           | frame.data[8]);

    assign wr_go = psel & penable & s_reg.pready & pwrite;
    assign rd_go = psel & penable & s_reg.pready & ~pwrite;
    assign mapped = paddr inside {srcs_pkg::OFS_CTRL_STAT,
        srcs_pkg::OFS_RX_DATA, srcs_pkg::OFS_BAUD_DIV,
        srcs_pkg::OFS_IRQ_STAT, srcs_pkg::OFS_IRQ_CLR,
        srcs_pkg::OFS_IRQ_EN};
    assign csr_view = {s_reg.ctrl, s_reg.framing_error_flag,
        s_reg.overrun_error_flag, s_reg.received_ninth_bit};

    // bus, divider, buffer and interrupt bookkeeping
    always_comb begin
        s_next = s_reg;
        ev = '0;
        // baud divider: one tick every baud_div+1 clocks
        s_next.tick = 1'b0;
        if (s_reg.div_cnt == s_reg.baud_div) begin
            s_next.div_cnt = 8'h00;
            s_next.tick = 1'b1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 8'h01;
        end
        // reading the buffer frees it for the next byte
        if (rd_go && paddr == srcs_pkg::OFS_RX_DATA) begin
            s_next.buf_full = 1'b0;
        end
        if (wr_go && mapped) begin
            case (paddr)
                srcs_pkg::OFS_CTRL_STAT: begin
                    s_next.ctrl = pwdata[7:3];
                    // overrun is cleared only by dropping the enable
                    if (!pwdata[srcs_pkg::POS_CONT_RX_EN]) begin
                        s_next.overrun_error_flag = 1'b0;
                    end
                end
                srcs_pkg::OFS_BAUD_DIV: begin
                    s_next.baud_div = pwdata[7:0];
                    s_next.div_cnt = 8'h00;
                end
                srcs_pkg::OFS_IRQ_CLR: begin
                    s_next.irq_stat = s_reg.irq_stat
                                    & ~pwdata[srcs_pkg::IRQ_W-1:0];
                end
                srcs_pkg::OFS_IRQ_EN: begin
                    s_next.irq_en = pwdata[srcs_pkg::IRQ_W-1:0];
                end
                default: ;
            endcase
        end
        // a frame that finds the buffer still full is lost
        if (accept) begin
            if (s_reg.buf_full) begin
                s_next.overrun_error_flag = 1'b1;
                ev[srcs_pkg::IRQ_OVERRUN] = 1'b1;
            end else begin
                s_next.receive_data_buffer = frame.data[7:0];
                s_next.received_ninth_bit = frame.data[8];
                s_next.framing_error_flag = ~frame.stop_ok;
                s_next.buf_full = 1'b1;
                ev[srcs_pkg::IRQ_RX_LOAD] = 1'b1;
                ev[srcs_pkg::IRQ_FRAMING] = ~frame.stop_ok;
            end
        end
        // events win over a clear in the same cycle
        s_next.irq_stat = s_next.irq_stat | ev;
        s_next.irq = |(s_next.irq_stat & s_next.irq_en);
        // zero-wait answer: ready rises in the access cycle
        s_next.pready = psel & ~penable;
        s_next.pslverr = psel & ~penable & ~mapped;
        s_next.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                srcs_pkg::OFS_CTRL_STAT:
                    s_next.prdata = {24'h00_0000, csr_view};
                srcs_pkg::OFS_RX_DATA:
                    s_next.prdata = {24'h00_0000, s_reg.receive_data_buffer};
                srcs_pkg::OFS_BAUD_DIV:
                    s_next.prdata = {24'h00_0000, s_reg.baud_div};
                srcs_pkg::OFS_IRQ_STAT:
                    s_next.prdata = {29'h0000_0000, s_reg.irq_stat};
                srcs_pkg::OFS_IRQ_EN:
                    s_next.prdata = {29'h0000_0000, s_reg.irq_en};
                default: s_next.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{baud_div: srcs_pkg::RST_BAUD_DIV,
                       irq_en: srcs_pkg::RST_IRQ_EN, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rx_off_idle_a: assert property (
        !s_reg.ctrl.continuous_receive_enable |-> ##1 !frame.valid)
        else $error("frame seen with receiver off");
    addr_filter_a: assert property (
        frame.valid && s_reg.ctrl.nine_bit_receive_select
        && s_reg.ctrl.address_detect_enable && !frame.data[8]
        |=> !s_reg.irq_stat[srcs_pkg::IRQ_RX_LOAD]
            || $past(s_reg.irq_stat[srcs_pkg::IRQ_RX_LOAD]))
        else $error("data frame loaded under address detect");
    all_bytes_a: assert property (
        frame.valid && !s_reg.buf_full && !s_reg.overrun_error_flag
        && !s_reg.ctrl.address_detect_enable |=> s_reg.buf_full)
        else $error("byte dropped with address detect off");
    eight_bit_a: assert property (
        frame.valid && !s_reg.buf_full
        && !s_reg.ctrl.nine_bit_receive_select
        |=> s_reg.buf_full && !s_reg.received_ninth_bit)
        else $error("eight-bit frame filtered");
    ninth_bit_a: assert property (
        accept && !s_reg.buf_full
        |=> s_reg.received_ninth_bit == $past(frame.data[8]))
        else $error("ninth bit not stored");
    overrun_hold_a: assert property (
        s_reg.overrun_error_flag && s_reg.ctrl.continuous_receive_enable
        && !wr_go |=> s_reg.overrun_error_flag)
        else $error("overrun flag dropped early");
    overrun_set_a: assert property (
        accept && s_reg.buf_full |=> s_reg.overrun_error_flag
        && s_reg.irq_stat[srcs_pkg::IRQ_OVERRUN])
        else $error("overrun not flagged");
    framing_upd_a: assert property (
        accept && !s_reg.buf_full
        |=> s_reg.framing_error_flag == !$past(frame.stop_ok))
        else $error("framing flag not refreshed");
    apb_ready_a: assert property (
        psel && !penable |=> pready ##1 !pready || (psel && !penable))
        else $error("apb answer timing wrong");
    irq_level_a: assert property (
        |(s_reg.irq_stat & s_reg.irq_en) |-> irq)
        else $error("interrupt not raised");

    load_c: cover property (accept && !s_reg.buf_full);
    overrun_c: cover property (accept && s_reg.buf_full);
    addr_skip_c: cover property (frame.valid && !accept);
    framing_c: cover property (accept && !frame.stop_ok);
endmodule // srcs_rx_ctrl

// File: src/srcs_pkg.sv
package srcs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_STAT = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    // receive_control_status field positions
    localparam int POS_SERIAL_PORT_EN = 7;
    localparam int POS_NINE_BIT_SEL = 6;
    localparam int POS_SINGLE_RX_EN = 5;
    localparam int POS_CONT_RX_EN = 4;
    localparam int POS_ADDR_DET_EN = 3;
    localparam int POS_FRAMING_ERR = 2;
    localparam int POS_OVERRUN_ERR = 1;
    localparam int POS_NINTH_BIT = 0;
    // interrupt event positions
    localparam int IRQ_RX_LOAD = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_FRAMING = 2;
    localparam int IRQ_W = 3;
    // reset values
    localparam logic [7:0] RST_BAUD_DIV = 8'h00;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;
    // timing: samples per bit and start-bit check point
    localparam int OVERSAMPLE = 16;
    localparam int START_MID = OVERSAMPLE / 2;

    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit_receive_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
    } srcs_ctrl_t;

    typedef struct packed {
        logic valid;
        logic stop_ok;
        logic [8:0] data;
    } srcs_frame_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srcs_rx_st_t;
endpackage

// File: src/srcs_rx_shift.sv
`timescale 1ns/10ps
// oversampling receive shift register, lsb first
module srcs_rx_shift #(
    parameter int unsigned OVS = srcs_pkg::OVERSAMPLE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic sample_tick,
    input wire logic nine_bits,
    input wire logic rx_pin,
    output srcs_pkg::srcs_frame_t frame
);
    localparam int CW = $clog2(OVS);
    localparam logic [CW-1:0] LAST = CW'(OVS - 1);
    // start check sits half a bit in, whatever the ratio
    localparam logic [CW-1:0] MID = CW'(OVS / 2 - 1);

    // elaboration-time refusal of ratios the counters cannot serve
    if (OVS < 4 || OVS > 64) begin : g_bad_ovs
        $error("oversample ratio out of range");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        srcs_pkg::srcs_rx_st_t st;
        logic [CW-1:0] os_cnt;
        logic [3:0] bit_cnt;
        logic [8:0] shift;
        srcs_pkg::srcs_frame_t frame;
    } srcs_rx_state_t;

    srcs_rx_state_t s_reg;
    srcs_rx_state_t s_next;

    // one step of the bit sampler per oversample tick
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = rx_pin;
        s_next.sync2 = s_reg.sync1;
        s_next.frame.valid = 1'b0;
        case (s_reg.st)
            srcs_pkg::RX_IDLE: begin
                if (!s_reg.sync2) begin
                    s_next.st = srcs_pkg::RX_START;
                    s_next.os_cnt = '0;
                end
            end
            srcs_pkg::RX_START: begin
                if (sample_tick) begin
                    s_next.os_cnt = s_reg.os_cnt + 1'b1;
                    // a glitch shorter than half a bit is not a start
                    if (s_reg.os_cnt == MID) begin
                        s_next.st = s_reg.sync2 ? srcs_pkg::RX_IDLE
                                                : srcs_pkg::RX_DATA;
                        s_next.os_cnt = '0;
                        s_next.bit_cnt = 4'h0;
                    end
                end
            end
            srcs_pkg::RX_DATA: begin
                if (sample_tick) begin
                    s_next.os_cnt = s_reg.os_cnt + 1'b1;
                    if (s_reg.os_cnt == LAST) begin
                        // explicit wrap: ratio need not be a power of two
                        s_next.os_cnt = '0;
                        s_next.shift = {s_reg.sync2, s_reg.shift[8:1]};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                        if (s_reg.bit_cnt == (nine_bits ? 4'h8 : 4'h7)) begin
                            s_next.st = srcs_pkg::RX_STOP;
                        end
                    end
                end
            end
            srcs_pkg::RX_STOP: begin
                if (sample_tick) begin
                    s_next.os_cnt = s_reg.os_cnt + 1'b1;
                    if (s_reg.os_cnt == LAST) begin
                        s_next.os_cnt = '0;
                        s_next.st = srcs_pkg::RX_IDLE;
                        s_next.frame.valid = 1'b1;
                        s_next.frame.stop_ok = s_reg.sync2;
                        // 8-bit frames sit one place higher
                        s_next.frame.data = nine_bits ? s_reg.shift
                                          : {1'b0, s_reg.shift[8:1]};
                    end
                end
            end
            default: s_next.st = srcs_pkg::RX_IDLE;
        endcase
        if (!enable) begin
            s_next.st = srcs_pkg::RX_IDLE;
            s_next.frame.valid = 1'b0;
        end
    end

    // sync flops idle high like the line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{sync1: 1'b1, sync2: 1'b1, st: srcs_pkg::RX_IDLE,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign frame = s_reg.frame;
endmodule // srcs_rx_shift

// File: tb/srcs_tx_model.sv
`timescale 1ns/10ps
// remote transmitter: start, lsb-first data, one stop bit
module srcs_tx_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic [8:0] data,
    input wire logic nine,
    input wire logic bad_stop,
    output logic line,
    output logic busy
);
    localparam int BIT_CLKS = srcs_pkg::OVERSAMPLE; // divisor 0: tick a clock
    logic [11:0] fr;
    int nb;
    initial begin
        line = 1'h1;
        busy = 1'h0;
    end
    // line idles high; a low stop bit stands for a broken frame
    always @(posedge pclk) begin
        if (go) begin
            busy <= 1'h1;
            fr = nine ? {1'h1, ~bad_stop, data, 1'h0}
                      : {2'h3, ~bad_stop, data[7:0], 1'h0};
            nb = nine ? 11 : 10;
            for (int i = 0; i < nb; i++) begin
                line <= fr[i];
                repeat (BIT_CLKS) @(posedge pclk);
            end
            line <= 1'h1;
            busy <= 1'h0;
        end
    end
endmodule // srcs_tx_model

// File: tb/tb_serial_receive_control_status.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("wrong value t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module tb_serial_receive_control_status;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, v;
    logic err, go, nine, bad, line, busy;
    logic [8:0] d9;
    logic [31:0] seed = 32'h6731;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    srcs_rx_ctrl srcs_rx_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(line), .irq(irq));
    srcs_tx_model srcs_tx_model_inst (.pclk(pclk), .go(go), .data(d9),
        .nine(nine), .bad_stop(bad), .line(line), .busy(busy));
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected control/status word
    function automatic logic [31:0] exp_stat(input logic [7:0] c,
        input logic fe, input logic oe, input logic b9);
        return {24'h0, c[7:3], fe, oe, b9};
    endfunction
    // one apb transfer; answer taken at the rising edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // no wait count assumed: only the hang guard ends this
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic send(input logic [8:0] d, input logic n, input logic b);
        @(posedge pclk);
        d9 <= d;
        nine <= n;
        bad <= b;
        go <= 1'h1;
        @(posedge pclk);
        go <= 1'h0;
        do @(negedge pclk); while (busy === 1'h1);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (irq !== 1'h1 && k < 80);
    endtask
    // event clear then let the registered irq settle
    task automatic clr();
        apb(1'h1, srcs_pkg::OFS_IRQ_CLR, 32'h7);
        repeat (2) @(negedge pclk);
    endtask
    task final_report;
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard: about seven times the expected run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, go, nine, bad} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        d9 = 9'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'h0, 8'h18, 32'h0);
        `CHK(err, 1'h1)
        // divisor reset value and read-back, then back to full speed
        apb(1'h0, srcs_pkg::OFS_BAUD_DIV, 32'h0);
        `CHK(rdat, {24'h0, srcs_pkg::RST_BAUD_DIV})
        v = rnd();
        apb(1'h1, srcs_pkg::OFS_BAUD_DIV, v);
        apb(1'h0, srcs_pkg::OFS_BAUD_DIV, 32'h0);
        `CHK(rdat, {24'h0, v[7:0]})
        apb(1'h1, srcs_pkg::OFS_BAUD_DIV, 32'h0);
        apb(1'h1, srcs_pkg::OFS_IRQ_EN, 32'h7);
        // receiver off, single enable alone must not start it
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'hA0);
        v = rnd();
        send(v[8:0], 1'h1, 1'h0);
        repeat (40) @(negedge pclk);
        apb(1'h0, srcs_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat, exp_stat(8'hA0, 1'h0, 1'h0, 1'h0))
        // eight-bit frames with address detect set, ninth bit ignored
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'h98);
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            send(v[8:0], 1'h0, 1'h0);
            wait_irq();
            `CHK(irq, 1'h1)
            apb(1'h0, srcs_pkg::OFS_RX_DATA, 32'h0);
            `CHK(rdat, {24'h0, v[7:0]})
            clr();
            `CHK(irq, 1'h0)
        end
        // nine-bit, no address detect: every frame accepted
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'hD0);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            send(v[8:0], 1'h1, 1'h0);
            wait_irq();
            apb(1'h0, srcs_pkg::OFS_RX_DATA, 32'h0);
            `CHK(rdat, {24'h0, v[7:0]})
            apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
            `CHK(rdat, exp_stat(8'hD0, 1'h0, 1'h0, v[8]))
            clr();
        end
        // address detect: data frame dropped, address frame loaded
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'hD8);
        v = rnd();
        send({1'h0, v[7:0]}, 1'h1, 1'h0);
        repeat (40) @(negedge pclk);
        apb(1'h0, srcs_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        send({1'h1, v[15:8]}, 1'h1, 1'h0);
        wait_irq();
        `CHK(irq, 1'h1)
        apb(1'h1, srcs_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(negedge pclk);
        `CHK(irq, 1'h0)
        apb(1'h1, srcs_pkg::OFS_IRQ_EN, 32'h7);
        repeat (2) @(negedge pclk);
        `CHK(irq, 1'h1)
        apb(1'h0, srcs_pkg::OFS_RX_DATA, 32'h0);
        `CHK(rdat, {24'h0, v[15:8]})
        clr();
        // overrun: second frame with buffer still full
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'h90);
        v = rnd();
        send(v[8:0], 1'h0, 1'h0);
        send(v[24:16], 1'h0, 1'h0);
        repeat (40) @(negedge pclk);
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat[7:1], exp_stat(8'h90, 1'h0, 1'h1, 1'h0) >> 1)
        apb(1'h0, srcs_pkg::OFS_RX_DATA, 32'h0);
        `CHK(rdat, {24'h0, v[7:0]})
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat[1], 1'h1)
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'h80);
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat[7:1], exp_stat(8'h80, 1'h0, 1'h0, 1'h0) >> 1)
        clr();
        // framing error set by a bad stop, refreshed by the next good byte
        apb(1'h1, srcs_pkg::OFS_CTRL_STAT, 32'h90);
        send(v[8:0], 1'h0, 1'h1);
        wait_irq();
        apb(1'h0, srcs_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK(rdat, (32'h1 << srcs_pkg::IRQ_FRAMING) | (32'h1 << srcs_pkg::IRQ_RX_LOAD))
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat[2], 1'h1)
        apb(1'h0, srcs_pkg::OFS_RX_DATA, 32'h0);
        clr();
        send(v[8:0], 1'h0, 1'h0);
        wait_irq();
        apb(1'h0, srcs_pkg::OFS_CTRL_STAT, 32'h0);
        `CHK(rdat[2], 1'h0)
        final_report;
    end
endmodule // tb_serial_receive_control_status
